// *** hdl/brbl_pkg.sv ***
package brbl_pkg;

    // ************************************************************
    // burst geometry
    // ************************************************************
    localparam int GROUP_W = 3;             // 8-word group, offset bits
    localparam int SEG_W = 7;               // 128-word internal boundary
    localparam int ADDR_W_DEF = 25;         // word address width
    localparam int BANK_W_DEF = 4;          // 16 banks, top address bits
    localparam logic [2:0] LAST_IN_GROUP = 3'h7;

    // ************************************************************
    // burst length codes
    // ************************************************************
    localparam logic [2:0] MODE_CONT = 3'h0;
    localparam logic [2:0] MODE_WRAP8 = 3'h2;
    localparam logic [2:0] MODE_WRAP16 = 3'h3;

    // ************************************************************
    // initial wait-state field
    // ************************************************************
    localparam logic [3:0] WAIT_CODE_MIN = 4'h1;   // code 1 = 3 wait states
    localparam logic [3:0] WAIT_CODE_MAX = 4'hB;   // code 11 = 13 wait states
    localparam logic [3:0] WAIT_CODE_BASE = 4'h2;  // wait states = code + 2
    localparam logic [3:0] WAIT_GROUP_REF = 4'h8;  // group-crossing pivot
    localparam logic [3:0] WAIT_SEG_ONE = 4'h9;    // one extra at 128 words
    localparam logic [3:0] WAIT_SEG_TWO = 4'hA;    // two extra at 128 words
    localparam logic [3:0] EXTRA_ONE = 4'h1;
    localparam logic [3:0] EXTRA_TWO = 4'h2;

    // ************************************************************
    // burst sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        BRBL_IDLE,
        BRBL_LATENCY,
        BRBL_STREAM,
        BRBL_HALT
    } brbl_state_t;

endpackage

// *** hdl/brbl_burst_latency.sv ***
`timescale 1ns/100ps

// Functional notes
// RULE1: seven waits: offsets 1..7 add 0..6
// RULE2: six waits: offsets 3..7 add 1..5
// RULE3: five waits: offsets 4..7 add 1..4
// RULE4: four waits: offset 5 one, 7 three
// RULE5: three waits: offset 6 one, 7 two
// RULE6: 128-word crossing adds 0, 1 or 2
// RULE7: continuous burst wraps to address zero
// RULE8: burst ends by deselect, reset, new strobe
// RULE9: idle bank crossing gets boundary latency
// RULE10: busy bank crossing halts, data still driven
// RULE11: offset zero needs no group waits
// RULE12: group waits only continuous or 16-word
// RULE13: wrap modes never cross 128 words
// RULE14: wait field sets initial latency cycles
module brbl_burst_latency
    import brbl_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int BANK_W = BANK_W_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic burst_clk,
    input wire logic chip_select_n,
    input wire logic address_strobe_n,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [3:0] wait_code,
    input wire logic [2:0] burst_mode,
    input wire logic [(1<<BANK_W)-1:0] bank_busy,
    output logic data_valid,
    output logic data_oe_n,
    output logic [ADDR_W-1:0] word_addr,
    output logic inserted_wait_cycle
);

    // ************************************************************
    // state record
    // ************************************************************
    localparam int PIN_W = ADDR_W + 3;
    // pins at their idle levels: clock low, deselected, no strobe
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b0, 1'b1, 1'b1, {ADDR_W{1'b0}}};

    typedef struct packed {
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        logic [PIN_W-1:0] pin_s3;
        logic [PIN_W-1:0] pin_q;
        brbl_state_t state;
        logic [3:0] init_wait;
        logic [3:0] lat;
        logic [3:0] wait_left;
        logic [2:0] mode;
        logic [2:0] words;
        logic crossed;
        logic [ADDR_W-1:0] addr;
        logic valid;
        logic oe_n;
        logic wait_pulse;
    } brbl_regs_t;

    brbl_regs_t r;
    brbl_regs_t next_r;

    // ************************************************************
    // latency functions
    // ************************************************************
    // wait states at the first 8-word crossing, by start offset
    function automatic logic [3:0] group_extra(input logic [3:0] init_wait,
                                               input logic [2:0] off);
        logic [4:0] sum;
        logic [3:0] res;
        sum = {1'b0, init_wait} + {2'b00, off};
        res = 4'h0;
        if (sum > {1'b0, WAIT_GROUP_REF}) begin
            res = 4'(sum - {1'b0, WAIT_GROUP_REF});
        end
        if (res > {1'b0, off}) begin
            res = {1'b0, off};
        end
        return res; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE11
    endfunction

    // extra wait states at a 128-word or bank crossing
    function automatic logic [3:0] seg_extra(input logic [3:0] init_wait);
        logic [3:0] res;
        res = 4'h0;
        if (init_wait >= WAIT_SEG_TWO) begin
            res = EXTRA_TWO;
        end else if (init_wait == WAIT_SEG_ONE) begin
            res = EXTRA_ONE;
        end
        return res; // RULE6
    endfunction

    // ************************************************************
    // pin sampling and burst sequencing
    // ************************************************************
    logic [PIN_W-1:0] pins;
    logic link_rise;
    logic strobe_low;
    logic deselect;
    logic [ADDR_W-1:0] pin_addr;
    logic [ADDR_W-1:0] step_addr;
    logic [3:0] code;
    logic [3:0] extra;
    logic [BANK_W-1:0] new_bank;

    assign pins = {burst_clk, chip_select_n, address_strobe_n, addr_in};

    always_comb begin
        next_r = r;
        next_r.wait_pulse = 1'b0;
        extra = 4'h0;
        step_addr = r.addr;
        new_bank = '0;
        // three-stage sampling, a bit changes once stages two and three agree
        next_r.pin_s1 = pins;
        next_r.pin_s2 = r.pin_s1;
        next_r.pin_s3 = r.pin_s2;
        for (int i = 0; i < PIN_W; i++) begin
            if (r.pin_s2[i] == r.pin_s3[i]) begin
                next_r.pin_q[i] = r.pin_s3[i];
            end
        end
        link_rise = next_r.pin_q[PIN_W-1] && !r.pin_q[PIN_W-1];
        deselect = next_r.pin_q[PIN_W-2];
        strobe_low = !next_r.pin_q[PIN_W-3];
        pin_addr = next_r.pin_q[ADDR_W-1:0];
        // reserved wait codes fall back to the longest latency
        code = wait_code;
        if (code < WAIT_CODE_MIN || code > WAIT_CODE_MAX) begin
            code = WAIT_CODE_MAX;
        end
        if (deselect) begin
            // chip deselected ends any burst at once
            next_r.state = BRBL_IDLE; // RULE8
            next_r.valid = 1'b0;
            next_r.oe_n = 1'b1;
        end else if (link_rise && strobe_low) begin
            // new start address, restarts the initial latency
            next_r.state = BRBL_LATENCY; // RULE8
            next_r.addr = pin_addr;
            next_r.init_wait = code + WAIT_CODE_BASE; // RULE14
            next_r.lat = code + WAIT_CODE_BASE;
            next_r.mode = burst_mode;
            next_r.words = 3'h0;
            next_r.crossed = 1'b0;
            next_r.wait_left = 4'h0;
            next_r.valid = 1'b0;
            next_r.oe_n = 1'b0;
        end else if (link_rise) begin
            unique case (r.state)
                BRBL_IDLE: begin
                    next_r.valid = 1'b0;
                end
                BRBL_LATENCY: begin
                    // first word on the programmed edge after the strobe
                    next_r.lat = r.lat - 4'h1; // RULE14
                    if (r.lat == 4'h1) begin
                        next_r.state = BRBL_STREAM;
                        next_r.valid = 1'b1;
                    end
                end
                BRBL_STREAM: begin
                    if (r.wait_left != 4'h0) begin
                        // boundary wait cycles, data valid again on the last count
                        next_r.wait_left = r.wait_left - 4'h1;
                        next_r.wait_pulse = r.wait_left != 4'h1;
                        next_r.valid = r.wait_left == 4'h1;
                    end else if (r.mode == MODE_WRAP8 && r.words == LAST_IN_GROUP) begin
                        // eighth word stays driven until the burst is ended
                        next_r.valid = 1'b1;
                    end else begin
                        next_r.words = r.words + 3'h1;
                        unique case (r.mode)
                            MODE_WRAP8: begin
                                step_addr[GROUP_W-1:0] = r.addr[GROUP_W-1:0] + 3'h1;
                            end
                            MODE_WRAP16: begin
                                step_addr[GROUP_W:0] = r.addr[GROUP_W:0] + 4'h1;
                            end
                            default: begin
                                // wraps to zero past the top word
                                step_addr = r.addr + 1'b1; // RULE7
                            end
                        endcase
                        // first 8-word crossing, continuous and 16-word only
                        if (r.mode != MODE_WRAP8 && !r.crossed
                                && r.addr[GROUP_W-1:0] == LAST_IN_GROUP) begin
                            next_r.crossed = 1'b1;
                            extra = group_extra(r.init_wait,
                                3'(r.addr[GROUP_W-1:0] - r.words)); // RULE12
                        end
                        // 128-word crossing only reachable when continuous
                        if (r.mode == MODE_CONT
                                && step_addr[SEG_W-1:0] == '0) begin // RULE13
                            extra = 4'(extra + seg_extra(r.init_wait)); // RULE6 RULE9
                        end
                        new_bank = step_addr[ADDR_W-1:ADDR_W-BANK_W];
                        next_r.addr = step_addr;
                        if (new_bank != r.addr[ADDR_W-1:ADDR_W-BANK_W]
                                && bank_busy[new_bank]) begin
                            // busy bank: stop, keep the bus driven
                            next_r.state = BRBL_HALT; // RULE10
                            next_r.valid = 1'b0;
                        end else if (extra != 4'h0) begin
                            next_r.wait_left = extra;
                            next_r.wait_pulse = 1'b1;
                            next_r.valid = 1'b0;
                        end else begin
                            next_r.valid = 1'b1;
                        end
                    end
                end
                BRBL_HALT: begin
                    next_r.valid = 1'b0;
                    next_r.oe_n = 1'b0; // RULE10
                end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // reset terminates any burst
            r <= '{pin_s1: PIN_IDLE, pin_s2: PIN_IDLE, pin_s3: PIN_IDLE, // RULE8
                   pin_q: PIN_IDLE, state: BRBL_IDLE, init_wait: 4'h0, lat: 4'h0,
                   wait_left: 4'h0,
                   mode: MODE_CONT, words: 3'h0, crossed: 1'b0, addr: '0,
                   valid: 1'b0, oe_n: 1'b1, wait_pulse: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state record
    assign data_valid = r.valid;
    assign data_oe_n = r.oe_n;
    assign word_addr = r.addr;
    assign inserted_wait_cycle = r.wait_pulse;

endmodule

// *** dv/brbl_burst_latency_properties.sv ***
`timescale 1ns/100ps
// ****
// output checks
// ****
module brbl_burst_latency_properties
    import brbl_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int BANK_W = BANK_W_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic address_strobe_n,
    input wire logic [2:0] burst_mode,
    input wire logic [(1<<BANK_W)-1:0] bank_busy,
    input wire logic data_valid,
    input wire logic data_oe_n,
    input wire logic [ADDR_W-1:0] word_addr,
    input wire logic inserted_wait_cycle
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // outputs tied to pins and to each other
    a_deselect_quiet: assert property (chip_select_n [*8] |-> data_oe_n && !data_valid)
        else $error("active after deselect");
    a_oe_held: assert property (!data_oe_n && !chip_select_n |=> !data_oe_n)
        else $error("bus dropped");
    a_valid_driven: assert property (data_valid |-> !data_oe_n)
        else $error("valid undriven");
    a_wait_no_valid: assert property (inserted_wait_cycle |-> !data_valid)
        else $error("valid in wait");
    a_busy_halt: assert property (data_valid |-> !bank_busy[word_addr[ADDR_W-1-:BANK_W]])
        else $error("busy bank read");
    a_cont_step: assert property (data_valid && $past(data_valid) && $changed(word_addr)
        && address_strobe_n && burst_mode == MODE_CONT |-> word_addr == $past(word_addr) + 1'b1)
        else $error("bad step");
    a_wrap8_group: assert property (data_valid && $past(data_valid) && address_strobe_n
        && burst_mode == MODE_WRAP8 |-> (word_addr >> 3) == ($past(word_addr) >> 3))
        else $error("left 8 group");
    a_wrap16_group: assert property (data_valid && $past(data_valid) && address_strobe_n
        && burst_mode == MODE_WRAP16 |-> (word_addr >> 4) == ($past(word_addr) >> 4))
        else $error("left 16 group");
endmodule
bind brbl_burst_latency brbl_burst_latency_properties #(.ADDR_W(ADDR_W), .BANK_W(BANK_W))
    i_brbl_burst_latency_properties (.ref_clk(ref_clk), .rst_n(rst_n),
    .chip_select_n(chip_select_n), .address_strobe_n(address_strobe_n),
    .burst_mode(burst_mode), .bank_busy(bank_busy), .data_valid(data_valid),
    .data_oe_n(data_oe_n), .word_addr(word_addr), .inserted_wait_cycle(inserted_wait_cycle));

// *** dv/brbl_host_model.sv ***
`timescale 1ns/100ps
// ****
// host: burst clock, select, strobe
// ****
module brbl_host_model
    import brbl_pkg::*;
(
    input wire logic ref_clk,
    output logic burst_clk,
    output logic chip_select_n,
    output logic address_strobe_n,
    output logic [ADDR_W_DEF-1:0] addr_in
);
    // idle: deselected, clock parked low
    initial begin
        burst_clk = 1'b0;
        chip_select_n = 1'b1;
        address_strobe_n = 1'b1;
        addr_in = 25'h0000000;
    end
    // 125 ns periods, only inside a frame
    task automatic pulse(input int n);
        repeat (n) begin
            #31.2 burst_clk = 1'b1;
            #62.5 burst_clk = 1'b0;
            #31.3;
        end
    endtask
    // latch a start address, ends any running burst
    task automatic start(input logic [ADDR_W_DEF-1:0] a);
        @(negedge ref_clk);
        chip_select_n = 1'b0;
        address_strobe_n = 1'b0;
        addr_in = a;
        #31.2 burst_clk = 1'b1;
        #62.5 burst_clk = 1'b0;
        // release 26.3 ns after the falling edge, then finish the 125 ns period
        #26.3 address_strobe_n = 1'b1;
        addr_in = ~a; // no stale address
        #5;
    endtask
    // deselect ends the burst
    task automatic stop();
        @(negedge ref_clk);
        chip_select_n = 1'b1;
    endtask
endmodule

// *** dv/brbl_burst_latency_tb_top.sv ***
`timescale 1ns/100ps
// ****
// burst latency bench
// ****
module brbl_burst_latency_tb_top
    import brbl_pkg::*;
;
    logic ref_clk, rst_n, burst_clk, chip_select_n, address_strobe_n;
    logic data_valid, data_oe_n, inserted_wait_cycle;
    logic [24:0] addr_in, word_addr, a;
    logic [3:0] wait_code;
    logic [2:0] burst_mode, m;
    logic [15:0] bank_busy;
    logic [26:0] exp_q[$];
    logic [31:0] seed = 32'h00015189;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [15:0] exp_waits = 16'h0000;
    logic [15:0] seen_waits = 16'h0000;
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    brbl_host_model i_brbl_host_model (.ref_clk(ref_clk), .burst_clk(burst_clk),
        .chip_select_n(chip_select_n), .address_strobe_n(address_strobe_n), .addr_in(addr_in));
    brbl_burst_latency i_brbl_burst_latency (.ref_clk(ref_clk), .rst_n(rst_n),
        .burst_clk(burst_clk), .chip_select_n(chip_select_n),
        .address_strobe_n(address_strobe_n), .addr_in(addr_in), .wait_code(wait_code),
        .burst_mode(burst_mode), .bank_busy(bank_busy), .data_valid(data_valid),
        .data_oe_n(data_oe_n), .word_addr(word_addr), .inserted_wait_cycle(inserted_wait_cycle));
    // compare and report
    task automatic chk(input logic [26:0] e, input logic [26:0] g);
        checks_done++;
        if (g[26:25] !== e[26:25] || (e[25] && g[24:0] !== e[24:0])) begin
            n_mismatch++;
            $display("wrong value word exp %h got %h", e, g);
        end
    endtask
    task automatic chk_waits(input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value waits exp %0d got %0d", e, g);
        end
    endtask
    task automatic close_out();
        // notes never matched by an output count as one miss in all
        if (exp_q.size() != 0) n_mismatch++;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected state per burst clock rise
    task automatic plan(input logic [24:0] a, input int w, input logic [2:0] m, input int n);
        logic [24:0] nx;
        int ext, cnt, off, words;
        bit first;
        bit busy;
        nx = a;
        off = a[2:0];
        first = 1'b1;
        words = 1;
        cnt = w + 1;
        repeat (w) exp_q.push_back(27'h0000000);
        exp_q.push_back({2'b01, a});
        while (cnt < n) begin
            if (m == MODE_WRAP8) nx = (words < 8) ? {a[24:3], nx[2:0] + 3'h1} : nx;
            else if (m == MODE_WRAP16) nx = {a[24:4], nx[3:0] + 4'h1};
            else nx = nx + 25'h0000001;
            words++;
            ext = 0;
            if (m != MODE_WRAP8 && nx[2:0] == 3'h0 && first) begin
                first = 1'b0;
                ext = (w + off < 8) ? 0 : (w > 8) ? off : w + off - 8;
            end
            if (m == MODE_CONT && nx[6:0] == 7'h00) ext += (w > 9) ? 2 : (w == 9);
            busy = bank_busy[nx[24:21]];
            if (busy) ext = n;
            for (int j = 0; j <= ext && cnt < n; j++) begin
                exp_q.push_back((j < ext) ? 27'h0000000 : {2'b01, nx});
                if (j < ext && !busy) exp_waits++;
                cnt++;
            end
        end
    endtask
    // one burst of n rises
    task automatic burst(input logic [24:0] a, input logic [3:0] c, input logic [2:0] m, input int n);
        logic [3:0] cc;
        // reserved wait codes run with the longest latency
        cc = (c < WAIT_CODE_MIN || c > WAIT_CODE_MAX) ? WAIT_CODE_MAX : c;
        @(negedge ref_clk);
        wait_code = c;
        burst_mode = m;
        plan(a, int'(cc) + int'(WAIT_CODE_BASE), m, n);
        i_brbl_host_model.start(a);
        i_brbl_host_model.pulse(n - 1);
    endtask
    task automatic quit(input string name);
        i_brbl_host_model.stop();
        repeat (8) @(negedge ref_clk);
        chk({2'b10, 25'h0000000}, {data_oe_n, data_valid, word_addr});
        chk_waits(exp_waits, seen_waits);
        $display("test %s done", name);
    endtask
    // watcher: oldest note against the settled outputs
    always @(negedge burst_clk) begin
        #30;
        if (exp_q.size() > 0) chk(exp_q.pop_front(), {data_oe_n, data_valid, word_addr});
    end
    // running count of boundary wait pulses
    always @(negedge ref_clk) begin
        seen_waits <= seen_waits + {15'h0000, inserted_wait_cycle};
    end
    // hang guard
    initial begin
        #600000;
        n_mismatch++;
        close_out();
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        wait_code = 4'h1;
        burst_mode = MODE_CONT;
        bank_busy = 16'h0000;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        for (int c = 1; c < 12; c++) begin
            for (int o = 0; o < 8; o++) begin
                seed = lfsr(seed);
                a = {seed[17:0], 4'hF, o[2:0]};
                m = (o == 3) ? MODE_WRAP8 : o[0] ? MODE_WRAP16 : MODE_CONT;
                burst(a, c[3:0], m, c + 17);
                quit("offsets");
            end
        end
        burst(25'h1FFFFFE, 4'h1, MODE_CONT, 12);
        quit("top wrap");
        bank_busy = 16'h0008;
        burst(25'h03FFFFC, 4'h7, MODE_CONT, 16);
        quit("idle bank");
        burst(25'h05FFFFC, 4'h3, MODE_CONT, 14);
        quit("busy bank");
        bank_busy = 16'h0000;
        burst(25'h0000123, 4'h2, MODE_CONT, 7);
        burst(25'h0000456, 4'h2, MODE_CONT, 9);
        quit("restart");
        burst(25'h000017D, 4'h0, MODE_CONT, 24);
        quit("reserved code");
        burst(25'h0000789, 4'h1, MODE_CONT, 6);
        @(negedge ref_clk);
        rst_n = 1'b0;
        i_brbl_host_model.stop();
        chk({2'b10, 25'h0000000}, {data_oe_n, data_valid, word_addr});
        rst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        $display("test reset done");
        close_out();
    end
endmodule
